/* verilog/fsc_pkg.sv */
// Package for the flash page signature checker: register map, field layout,
// reset values, command codes and shared types.
// Assumes a 32-bit AXI4-Lite register bus and a 32-bit flash read port.
package fsc_pkg;

  localparam int FSC_AXI_AW = 8;
  localparam int FSC_DW     = 32;
  localparam int FSC_CRC_W  = 24;
  localparam int FSC_PAGE_SHIFT = 9;
  localparam int FSC_PAGE_W = FSC_DW - FSC_PAGE_SHIFT;

  // Register byte offsets
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_START_LO = 8'h00;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_START_HI = 8'h04;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_END_LO   = 8'h08;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_END_HI   = 8'h0c;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_CMD      = 8'h10;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_STATUS   = 8'h14;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_SIG      = 8'h18;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_IRQ_STAT = 8'h1c;
  localparam logic [FSC_AXI_AW-1:0] FSC_OFS_IRQ_MASK = 8'h20;

  // Command and status encodings
  localparam logic [7:0] FSC_CMD_SIGN   = 8'h0a;
  localparam logic [1:0] FSC_RES_NONE   = 2'h0;
  localparam logic [1:0] FSC_RES_PASS   = 2'h1;
  localparam logic [1:0] FSC_RES_FAIL   = 2'h2;
  localparam int FSC_ST_BUSY_BIT  = 2;
  localparam int FSC_ST_RES_LSB   = 4;
  localparam int FSC_ST_KFAIL_BIT = 6;

  // Interrupt status bits
  localparam int FSC_IRQ_DONE = 0;
  localparam int FSC_IRQ_FAIL = 1;
  localparam int FSC_IRQ_W    = 2;

  // CRC: x^24 + x^23 + x^6 + x^5 + x + 1
  localparam logic [FSC_CRC_W-1:0] FSC_CRC_POLY = 24'h800063;
  localparam logic [FSC_CRC_W-1:0] FSC_CRC_INIT = 24'hffffff;
  localparam logic [FSC_DW-1:0]    FSC_REF_OFS  = 32'h000001fc;
  localparam logic [FSC_DW-1:0]    FSC_WORD_STEP = 32'h00000004;

  localparam logic [1:0] FSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FSC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FSC_ST_BOOT,
    FSC_ST_IDLE,
    FSC_ST_READ
  } fsc_state_e;

  typedef struct packed {
    logic              req;
    logic [FSC_DW-1:0] addr;
  } fsc_flash_req_s;

endpackage

/* verilog/fsc_crc_word.sv */
// One-word step of the signature shift register, purely combinational.
// Feeds data bits most significant first into a Galois-form register.
`timescale 1ns/1ps
module fsc_crc_word
  import fsc_pkg::*;
#(
  parameter int DATA_W = FSC_DW
) (
  input  wire logic [FSC_CRC_W-1:0] crc_i,
  input  wire logic [DATA_W-1:0]    data_i,
  output logic      [FSC_CRC_W-1:0] crc_o
);

  always_comb begin
    logic [FSC_CRC_W-1:0] c;
    logic                 fb;
    c  = crc_i;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[FSC_CRC_W-1] ^ data_i[i];
      c  = {c[FSC_CRC_W-2:0], 1'b0} ^ (fb ? FSC_CRC_POLY : '0);
    end
    crc_o = c;
  end

endmodule

/* verilog/fsc_top.sv */
// Flash page signature checker: AXI4-Lite register slave, CRC engine that
// walks a page range of flash, boot-time kernel check and interrupt logic.
// Assumes a flash read port that answers each held request with an ack.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - 24-bit CRC, polynomial x24+x23+x6+x5+x+1
// - Signature built by 24-bit LFSR over flash
// - Range is whole pages, start through end
// - Top word of last page is reference
// - Command ten starts signature after addresses loaded
// - Finished result readable in signature register
// - Mismatch sets status bits 5:4 to 10
// - Other flash accesses stall while computing
// - Low nine address bits are ignored
// - Kernel checked after reset; failure blocks user
// - Kernel fail visible on debug only when enabled
module fsc_top
  import fsc_pkg::*;
#(
  parameter logic [FSC_PAGE_W-1:0] KERNEL_FIRST_PAGE = 23'h000000,
  parameter logic [FSC_PAGE_W-1:0] KERNEL_LAST_PAGE  = 23'h000003
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  input  wire logic [FSC_AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [FSC_DW-1:0]     s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [FSC_AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [FSC_DW-1:0]          s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  output fsc_flash_req_s             flash_rd_o,
  input  wire logic                  flash_ack_i,
  input  wire logic [FSC_DW-1:0]     flash_rdata_i,
  output logic                       flash_stall_o,
  output logic                       user_run_en_o,
  input  wire logic                  swd_enable_i,
  output logic                       swd_kernel_fail_o,
  output logic                       irq_o
);

  // Register state
  logic [15:0]            start_lo;
  logic [15:0]            start_hi;
  logic [15:0]            end_lo;
  logic [15:0]            end_hi;
  logic [1:0]             result;
  logic                   kernel_fail;
  logic                   user_run;
  logic [FSC_CRC_W-1:0]   sig_result;
  logic [FSC_IRQ_W-1:0]   irq_stat;
  logic [FSC_IRQ_W-1:0]   irq_mask;

  // Engine state
  fsc_state_e             state;
  fsc_state_e             next_state;
  logic [FSC_DW-1:0]      addr;
  logic [FSC_DW-1:0]      ref_addr;
  logic [FSC_CRC_W-1:0]   crc;
  logic [FSC_CRC_W-1:0]   next_crc;
  logic                   kernel_run;

  // Bus state
  logic                   aw_hold;
  logic [FSC_AXI_AW-1:0]  aw_addr;
  logic                   w_hold;
  logic [FSC_DW-1:0]      w_data;
  logic [3:0]             w_strb;
  logic                   bvalid;
  logic [1:0]             bresp;
  logic                   rvalid;
  logic [1:0]             rresp;
  logic [FSC_DW-1:0]      rdata;

  // AXI decode
  wire                    aw_hs  = s_axi_awvalid_i && !aw_hold;
  wire                    w_hs   = s_axi_wvalid_i && !w_hold;
  wire                    ar_hs  = s_axi_arvalid_i && !rvalid;
  wire                    wr_go  = aw_hold && w_hold && !bvalid;
  wire [FSC_DW-1:0]       wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire                    wr_slo = wr_go && aw_addr == FSC_OFS_START_LO;
  wire                    wr_shi = wr_go && aw_addr == FSC_OFS_START_HI;
  wire                    wr_elo = wr_go && aw_addr == FSC_OFS_END_LO;
  wire                    wr_ehi = wr_go && aw_addr == FSC_OFS_END_HI;
  wire                    wr_cmd = wr_go && aw_addr == FSC_OFS_CMD;
  wire                    wr_ist = wr_go && aw_addr == FSC_OFS_IRQ_STAT;
  wire                    wr_imk = wr_go && aw_addr == FSC_OFS_IRQ_MASK;
  wire                    wr_ro  = aw_addr == FSC_OFS_STATUS || aw_addr == FSC_OFS_SIG;
  wire                    wr_hit = wr_slo || wr_shi || wr_elo || wr_ehi || wr_cmd || wr_ist || wr_imk || wr_ro;

  // Engine decode
  wire                    busy      = state != FSC_ST_IDLE;
  wire [FSC_DW-1:0]       start_b   = {start_hi, start_lo};
  wire [FSC_DW-1:0]       end_b     = {end_hi, end_lo};
  wire [FSC_PAGE_W-1:0]   start_pg  = start_b[FSC_DW-1:FSC_PAGE_SHIFT];
  wire [FSC_PAGE_W-1:0]   end_pg    = end_b[FSC_DW-1:FSC_PAGE_SHIFT];
  wire                    cmd_go    = wr_cmd && w_strb[0] && w_data[7:0] == FSC_CMD_SIGN && !busy;
  // A reversed range fails at once rather than walking past the array end
  wire                    bad_range = cmd_go && start_pg > end_pg;
  wire                    run_start = cmd_go && !bad_range;
  wire                    at_ref    = addr == ref_addr;
  wire                    finish    = state == FSC_ST_READ && flash_ack_i && at_ref;
  // The engine builds 24 bits, so the top byte of a valid reference is zero
  wire                    match     = flash_rdata_i == {8'h00, crc};
  wire                    kern_done = finish && kernel_run;
  wire                    sign_done = finish && !kernel_run;
  wire                    ev_done   = sign_done || bad_range;
  wire                    ev_fail   = (sign_done && !match) || bad_range;
  wire [FSC_IRQ_W-1:0]    irq_set   = {ev_fail, ev_done};
  wire [FSC_IRQ_W-1:0]    irq_clr   = wr_ist && w_strb[0] ? w_data[FSC_IRQ_W-1:0] : '0;
  wire [FSC_DW-1:0]       status_w  = {25'h0000000, kernel_fail, result, 1'b0, busy, 2'h0};

  // Read decode
  wire                    rd_slo = s_axi_araddr_i == FSC_OFS_START_LO;
  wire                    rd_shi = s_axi_araddr_i == FSC_OFS_START_HI;
  wire                    rd_elo = s_axi_araddr_i == FSC_OFS_END_LO;
  wire                    rd_ehi = s_axi_araddr_i == FSC_OFS_END_HI;
  wire                    rd_cmd = s_axi_araddr_i == FSC_OFS_CMD;
  wire                    rd_sta = s_axi_araddr_i == FSC_OFS_STATUS;
  wire                    rd_sig = s_axi_araddr_i == FSC_OFS_SIG;
  wire                    rd_ist = s_axi_araddr_i == FSC_OFS_IRQ_STAT;
  wire                    rd_imk = s_axi_araddr_i == FSC_OFS_IRQ_MASK;
  wire                    rd_hit = rd_slo || rd_shi || rd_elo || rd_ehi || rd_cmd || rd_sta || rd_sig
                                   || rd_ist || rd_imk;
  wire [FSC_DW-1:0]       rd_mux = rd_slo ? {16'h0000, start_lo} :
                                   rd_shi ? {16'h0000, start_hi} :
                                   rd_elo ? {16'h0000, end_lo} :
                                   rd_ehi ? {16'h0000, end_hi} :
                                   rd_sta ? status_w :
                                   rd_sig ? {8'h00, sig_result} :
                                   rd_ist ? {30'h00000000, irq_stat} :
                                   rd_imk ? {30'h00000000, irq_mask} : 32'h00000000;

  // Byte-lane merge for the 16-bit address halves
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [FSC_DW-1:0] d,
                                          input logic [FSC_DW-1:0] m);
    merge16 = (old_v & ~m[15:0]) | (d[15:0] & m[15:0]);
  endfunction

  // One word folds in per acknowledged read below the reference; a slow array only stretches the walk
  fsc_crc_word #(
    .DATA_W (FSC_DW)
  ) u_crc (
    .crc_i  (crc),
    .data_i (flash_rdata_i),
    .crc_o  (next_crc)
  );

  always_comb begin
    next_state = state;
    case (state)
      FSC_ST_BOOT: next_state = FSC_ST_READ;
      FSC_ST_IDLE: begin
        if (run_start) begin
          next_state = FSC_ST_READ;
        end
      end
      FSC_ST_READ: begin
        if (finish) begin
          next_state = FSC_ST_IDLE;
        end
      end
      default: next_state = FSC_ST_IDLE;
    endcase
  end

  // Outputs
  assign s_axi_awready_o   = !aw_hold;
  assign s_axi_wready_o    = !w_hold;
  assign s_axi_bvalid_o    = bvalid;
  assign s_axi_bresp_o     = bresp;
  assign s_axi_arready_o   = !rvalid;
  assign s_axi_rvalid_o    = rvalid;
  assign s_axi_rresp_o     = rresp;
  assign s_axi_rdata_o     = rdata;
  assign flash_rd_o        = '{req: state == FSC_ST_READ, addr: addr};
  // Every other flash master waits while the engine owns the array
  assign flash_stall_o     = busy;
  assign user_run_en_o     = user_run;
  assign swd_kernel_fail_o = swd_enable_i && kernel_fail;
  // Level output: high while any unmasked sticky status bit is set
  assign irq_o             = |(irq_stat & irq_mask);

  // Write address and data are held independently until both are present
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (aw_hs) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (w_hs) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Unmapped writes are dropped but still answered, so the master never hangs
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bvalid <= 1'b0;
      bresp  <= FSC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? FSC_RESP_OKAY : FSC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid <= 1'b0;
    end
  end

  // Read data is captured at the address handshake and held until taken
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid <= 1'b0;
      rresp  <= FSC_RESP_OKAY;
      rdata  <= '0;
    end else if (ar_hs) begin
      rvalid <= 1'b1;
      rresp  <= rd_hit ? FSC_RESP_OKAY : FSC_RESP_SLVERR;
      rdata  <= rd_mux;
    end else if (s_axi_rready_i) begin
      rvalid <= 1'b0;
    end
  end

  // Address halves; software is expected to load both pairs before the command
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_lo <= '0;
      start_hi <= '0;
      end_lo   <= '0;
      end_hi   <= '0;
    end else begin
      if (wr_slo) start_lo <= merge16(start_lo, w_data, wmask);
      if (wr_shi) start_hi <= merge16(start_hi, w_data, wmask);
      if (wr_elo) end_lo <= merge16(end_lo, w_data, wmask);
      if (wr_ehi) end_hi <= merge16(end_hi, w_data, wmask);
    end
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_imk && w_strb[0]) irq_mask <= w_data[FSC_IRQ_W-1:0];
    end
  end

  // Reset lands in the kernel check, so no command can start before it ends
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= FSC_ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Marks the walk started from reset as the kernel check
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kernel_run <= 1'b0;
    end else if (state == FSC_ST_BOOT) begin
      kernel_run <= 1'b1;
    end else if (run_start) begin
      kernel_run <= 1'b0;
    end
  end

  // Walk address, reference word address and running CRC
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr       <= '0;
      ref_addr   <= '0;
      crc        <= FSC_CRC_INIT;
    end else if (state == FSC_ST_BOOT) begin
      addr       <= {KERNEL_FIRST_PAGE, 9'h000};
      ref_addr   <= {KERNEL_LAST_PAGE, 9'h000} | FSC_REF_OFS;
      crc        <= FSC_CRC_INIT;
    end else if (run_start) begin
      addr       <= {start_pg, 9'h000};
      ref_addr   <= {end_pg, 9'h000} | FSC_REF_OFS;
      crc        <= FSC_CRC_INIT;
    end else if (state == FSC_ST_READ && flash_ack_i && !at_ref) begin
      // Reference word is never folded into the signature
      addr       <= addr + FSC_WORD_STEP;
      crc        <= next_crc;
    end
  end

  // User code stays held until the kernel check passes
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kernel_fail <= 1'b0;
      user_run    <= 1'b0;
    end else if (kern_done) begin
      kernel_fail <= !match;
      user_run    <= match;
    end
  end

  // Posting of signature results
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result      <= FSC_RES_NONE;
      sig_result  <= '0;
    end else if (bad_range) begin
      result      <= FSC_RES_FAIL;
    end else if (run_start) begin
      result      <= FSC_RES_NONE;
    end else if (sign_done) begin
      sig_result  <= crc;
      result      <= match ? FSC_RES_PASS : FSC_RES_FAIL;
    end
  end

endmodule

/* tb/fsc_sig_checker.sv */
// Port-level assertions for the flash page signature checker.
// Assumes it is bound to fsc_top and sees only its ports.
`timescale 1ns/1ps
module fsc_sig_checker
  import fsc_pkg::*;
(
  input wire logic           clk_sys_i,
  input wire logic           reset_n_i,
  input wire logic           s_axi_arvalid_i,
  input wire logic           s_axi_arready_o,
  input wire logic           s_axi_rvalid_o,
  input wire fsc_flash_req_s flash_rd_o,
  input wire logic           flash_ack_i,
  input wire logic           flash_stall_o,
  input wire logic           user_run_en_o,
  input wire logic           swd_enable_i,
  input wire logic           swd_kernel_fail_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  chk_req_stalls: assert property (flash_rd_o.req |-> flash_stall_o)
    else $error("engine read without stall");
  chk_req_holds: assert property (flash_rd_o.req && !flash_ack_i |=>
    flash_rd_o.req && $stable(flash_rd_o.addr)) else $error("read request dropped or moved");
  chk_word_step: assert property (flash_rd_o.req && flash_ack_i ##1 flash_rd_o.req |->
    flash_rd_o.addr == $past(flash_rd_o.addr) + FSC_WORD_STEP) else $error("address step wrong");
  chk_page_aligned: assert property ($rose(flash_rd_o.req) |-> flash_rd_o.addr[8:0] == 9'h000)
    else $error("walk not starting on page");
  chk_done_on_ack: assert property ($fell(flash_stall_o) |-> $past(flash_ack_i))
    else $error("stall ended without final word");
  chk_user_waits: assert property ($rose(user_run_en_o) |-> !flash_stall_o)
    else $error("user code enabled during check");
  chk_user_holds: assert property (user_run_en_o |=> user_run_en_o)
    else $error("user enable dropped");
  chk_swd_gated: assert property (swd_kernel_fail_o |-> swd_enable_i)
    else $error("kernel fail shown while debug off");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
endmodule

/* tb/fsc_flash_model.sv */
// Behavioural flash array answering the engine's word reads.
// Assumes the requester holds req and addr until the ack pulse.
`timescale 1ns/1ps
module fsc_flash_model
  import fsc_pkg::*;
(
  input  wire logic           clk_sys_i,
  input  wire logic           reset_n_i,
  input  wire fsc_flash_req_s flash_rd_i,
  output logic                flash_ack_o,
  output logic [FSC_DW-1:0]   flash_rdata_o
);
  logic [FSC_DW-1:0] mem [0:1023];
  logic [1:0]        wait_cnt;
  logic [FSC_DW-1:0] last;
  wire               slow = flash_rd_i.addr[2];

  // Odd words answer late so both prompt and slow replies occur
  assign flash_ack_o   = flash_rd_i.req && (wait_cnt == (slow ? 2'h2 : 2'h0));
  // Outside an ack the data toggles so a stale word never passes as fresh
  assign flash_rdata_o = flash_ack_o ? mem[flash_rd_i.addr[11:2]] : ~last;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 2'h0;
      last     <= 32'h0;
    end else begin
      wait_cnt <= (flash_rd_i.req && !flash_ack_o) ? wait_cnt + 2'h1 : 2'h0;
      last     <= flash_rdata_o;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the signature checker over AXI4-Lite.
// Assumes a flash model whose array the bench fills before reset.
`timescale 1ns/1ps
module testbench;
  import fsc_pkg::*;
  logic clk_sys_i, reset_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, swd_enable_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, flash_ack_i, flash_stall_o, user_run_en_o, swd_kernel_fail_o, irq_o;
  logic [7:0]     s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]    s_axi_wdata_i, s_axi_rdata_o, flash_rdata_i, rd;
  logic [3:0]     s_axi_wstrb_i;
  logic [1:0]     s_axi_bresp_o, s_axi_rresp_o, resp;
  fsc_flash_req_s flash_rd_o;
  int             error_cnt, n_checks;

  fsc_top #(.KERNEL_FIRST_PAGE(23'h000000), .KERNEL_LAST_PAGE(23'h000001)) dut (
    .clk_sys_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .flash_rd_o, .flash_ack_i, .flash_rdata_i, .flash_stall_o, .user_run_en_o,
    .swd_enable_i, .swd_kernel_fail_o, .irq_o);
  fsc_flash_model flash (.clk_sys_i, .reset_n_i, .flash_rd_i(flash_rd_o), .flash_ack_o(flash_ack_i),
    .flash_rdata_o(flash_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ready and valid are sampled at the falling edge, so they hold what the next rising edge sees
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    @(posedge clk_sys_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ra   = s_axi_awready_o && s_axi_awvalid_i;
      rw   = s_axi_wready_o && s_axi_wvalid_i;
      rb   = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (ra) s_axi_awvalid_i <= 1'b0;
      if (rw) s_axi_wvalid_i <= 1'b0;
    end while (!rb);
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ra, rv;
    @(posedge clk_sys_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ra   = s_axi_arready_o && s_axi_arvalid_i;
      rv   = s_axi_rvalid_o;
      rd   = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ra) s_axi_arvalid_i <= 1'b0;
    end while (!rv);
    s_axi_rready_i <= 1'b0;
  endtask

  function automatic logic [23:0] crc_range(input int first, input int last);
    logic [23:0] c;
    logic        fb;
    c = FSC_CRC_INIT;
    for (int w = first * 128; w < last * 128 + 127; w++)
      for (int i = 31; i >= 0; i--) begin
        fb = c[23] ^ flash.mem[w][i];
        c  = {c[22:0], 1'b0} ^ (fb ? FSC_CRC_POLY : 24'h000000);
      end
    return c;
  endfunction

  task automatic reset_and_boot;
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    do @(negedge clk_sys_i); while (flash_stall_o !== 1'b0);
  endtask

  task automatic run_sig(input logic [15:0] s, input logic [15:0] e, input logic [31:0] stat);
    axi_write(FSC_OFS_START_LO, {16'h0000, s});
    axi_write(FSC_OFS_START_HI, 32'h00000000);
    axi_write(FSC_OFS_END_LO, {16'h0000, e});
    axi_write(FSC_OFS_END_HI, 32'h00000000);
    axi_write(FSC_OFS_CMD, 32'h0000000b);
    axi_read(FSC_OFS_STATUS);
    check("busy on other code", 32'h0, {31'h0, rd[FSC_ST_BUSY_BIT]});
    axi_write(FSC_OFS_CMD, {24'h000000, FSC_CMD_SIGN});
    axi_read(FSC_OFS_STATUS);
    check("busy", 32'h1, {31'h0, rd[FSC_ST_BUSY_BIT]});
    do axi_read(FSC_OFS_STATUS); while (rd[FSC_ST_BUSY_BIT] !== 1'b0);
    check("status", stat, rd);
    axi_read(FSC_OFS_SIG);
    check("signature", {8'h00, crc_range(s[15:9], e[15:9])}, rd);
  endtask

  initial begin
    reset_n_i       = 1'b0;
    s_axi_awvalid_i = 1'b0;
    s_axi_wvalid_i  = 1'b0;
    s_axi_bready_i  = 1'b0;
    s_axi_arvalid_i = 1'b0;
    s_axi_rready_i  = 1'b0;
    s_axi_awaddr_i  = 8'h00;
    s_axi_araddr_i  = 8'h00;
    s_axi_wdata_i   = 32'h0;
    s_axi_wstrb_i   = 4'hf;
    swd_enable_i    = 1'b1;
    for (int i = 0; i < 1024; i++) flash.mem[i] = i * 32'h00010203 + 32'h13579bdf;
    flash.mem[255] = {8'h00, crc_range(0, 1)};
    flash.mem[767] = {8'h00, crc_range(4, 5)};
    flash.mem[895] = {8'h00, crc_range(6, 6)};
    reset_and_boot;
    check("user enable", 32'h1, {31'h0, user_run_en_o});
    axi_read(FSC_OFS_STATUS);
    check("boot status", 32'h0, rd);
    axi_read(FSC_OFS_END_HI);
    check("end high reset", 32'h0, rd);
    axi_read(8'h40);
    check("unmapped resp", {30'h0, FSC_RESP_SLVERR}, {30'h0, resp});
    axi_write(8'h40, 32'h00000000);
    check("unmapped write resp", {30'h0, FSC_RESP_SLVERR}, {30'h0, resp});
    axi_write(FSC_OFS_IRQ_MASK, 32'h1);
    check("write resp", {30'h0, FSC_RESP_OKAY}, {30'h0, resp});
    run_sig(16'h09ff, 16'h0bff, 32'h00000010);
    check("irq raised", 32'h1, {31'h0, irq_o});
    axi_write(FSC_OFS_IRQ_STAT, 32'h1);
    check("irq cleared", 32'h0, {31'h0, irq_o});
    flash.mem[767] ^= 32'h00000001;
    run_sig(16'h0800, 16'h0a00, 32'h00000020);
    axi_read(FSC_OFS_IRQ_STAT);
    check("irq status", 32'h3, rd);
    axi_write(FSC_OFS_IRQ_MASK, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq_o});
    axi_write(FSC_OFS_IRQ_STAT, 32'h3);
    run_sig(16'h0c00, 16'h0dff, 32'h00000010);
    axi_write(FSC_OFS_START_LO, 32'h00000c00);
    axi_write(FSC_OFS_END_LO, 32'h00000800);
    axi_write(FSC_OFS_CMD, {24'h000000, FSC_CMD_SIGN});
    axi_read(FSC_OFS_STATUS);
    check("reversed range", 32'h00000020, rd);
    flash.mem[255] ^= 32'h00000100;
    @(posedge clk_sys_i);
    swd_enable_i <= 1'b0;
    reset_and_boot;
    check("user blocked", 32'h0, {31'h0, user_run_en_o});
    check("debug off", 32'h0, {31'h0, swd_kernel_fail_o});
    @(posedge clk_sys_i);
    swd_enable_i <= 1'b1;
    @(negedge clk_sys_i);
    check("debug on", 32'h1, {31'h0, swd_kernel_fail_o});
    axi_read(FSC_OFS_STATUS);
    check("kernel fail bit", 32'h00000040, rd);
    report_and_stop;
  end

  // Each run is a few hundred cycles; twenty thousand leaves ample room
  initial begin
    #(20 * 20000);
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    report_and_stop;
  end
endmodule

bind fsc_top fsc_sig_checker chk (.clk_sys_i, .reset_n_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .flash_rd_o, .flash_ack_i, .flash_stall_o, .user_run_en_o, .swd_enable_i,
  .swd_kernel_fail_o);
